//--- lpm_pkg.sv
`default_nettype none
package lpm_pkg;
    // power mode codes shown on the mode output
    localparam logic [2:0] MODE_NORMAL = 3'h0;
    localparam logic [2:0] MODE_SUSPEND = 3'h1;
    localparam logic [2:0] MODE_STANDBY = 3'h2;
    localparam logic [2:0] MODE_COREOFF = 3'h3;
    localparam logic [2:0] MODE_TRANSIT = 3'h4;

    // bit positions of the synchronised pin bundle
    localparam int SYN_DP = 0;
    localparam int SYN_DM = 1;
    localparam int SYN_ROLE = 2;
    localparam int SYN_VBUS = 3;
    localparam int SYN_CTS = 4;
    localparam int SYN_CS = 5;
    localparam int SYN_INS0 = 6;
    localparam int SYN_INS1 = 7;
    localparam int SYN_SDIO0 = 8;
    localparam int SYN_SDIO1 = 9;
    localparam int SYN_CCLK = 10;
    localparam int SYN_VB37 = 11;
    localparam int SYN_PWR = 12;
    localparam int SYN_W = 13;
    // chip select is active low and core power good idles high
    localparam logic [SYN_W-1:0] SYN_RST = 13'h1020;

    // host interface modes
    localparam logic [1:0] HOST_SRAM = 2'h0;
    localparam logic [1:0] HOST_MUXED = 2'h1;
    localparam logic [1:0] HOST_CARD = 2'h2;

    // per-pad pull configuration
    localparam logic [1:0] PAD_TRISTATE = 2'h0;
    localparam logic [1:0] PAD_PULLUP = 2'h1;
    localparam logic [1:0] PAD_PULLDN = 2'h2;
    localparam logic [1:0] PAD_HOLD = 2'h3;

    // per-group drive strength codes
    localparam logic [1:0] DRV_FULL = 2'h0;
    localparam logic [1:0] DRV_3Q = 2'h1;
    localparam logic [1:0] DRV_HALF = 2'h2;
    localparam logic [1:0] DRV_QUARTER = 2'h3;

    // clock rate and oscillator/pll settle time before the core clock is released
    localparam int CLK_MHZ = 250;
    localparam int PLL_SETTLE_NS = 10000;
    localparam int PLL_SETTLE_CYC = (PLL_SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int SETTLE_W = 12;
endpackage
`default_nettype wire

//--- lpm_sync_if.sv
`timescale 1ns/1ps
`default_nettype none
// pin samples going in, filtered levels and change pulses coming out
interface lpm_sync_if #(parameter int W = 1);
    logic [W-1:0] raw; // unsynchronised pin levels
    logic [W-1:0] level; // filtered level
    logic [W-1:0] changed; // one-cycle pulse on a filtered change
    modport sync (input raw, output level, changed);
    modport user (output raw, input level, changed);
endinterface
`default_nettype wire

//--- lpm_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
// three-stage synchroniser; a level counts once stages two and three agree
module lpm_pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clock,
    input wire logic rst_n,
    lpm_sync_if.sync port
);
    logic [W-1:0] meta_r; // first stage, read only by the second
    logic [W-1:0] mid_r;
    logic [W-1:0] last_r;
    logic [W-1:0] level_r;
    logic [W-1:0] level_nxt;
    logic [W-1:0] changed_r;

    // keep the old level on bits whose late stages still disagree
    always_comb begin
        level_nxt = (~(mid_r ^ last_r) & last_r) | ((mid_r ^ last_r) & level_r);
    end

    ////////////////////////////////////////////////////////////////////
    // shift chain
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            meta_r <= RST_VAL;
            mid_r <= RST_VAL;
            last_r <= RST_VAL;
        end else begin
            meta_r <= port.raw;
            mid_r <= meta_r;
            last_r <= mid_r;
        end
    end

    // filtered level and its change pulse
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            level_r <= RST_VAL;
            changed_r <= '0;
        end else begin
            level_r <= level_nxt;
            changed_r <= level_r ^ level_nxt;
        end
    end

    assign port.level = level_r;
    assign port.changed = changed_r;
endmodule // lpm_pin_sync
`default_nettype wire

//--- lpm_power_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module lpm_power_ctrl import lpm_pkg::*; #(
    parameter int NUM_PADS = 8,
    parameter int NUM_GROUPS = 6,
    parameter int SETTLE_CYC = PLL_SETTLE_CYC
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic fwSuspendReq,
    input wire logic hostSuspendReq,
    input wire logic fwStandbyReq,
    input wire logic hostStandbyReq,
    input wire logic sleepCmdRx,
    input wire logic wakeCmdRx,
    input wire logic busIdle,
    input wire logic usbDp,
    input wire logic usbDm,
    input wire logic usbRoleIdentPin,
    input wire logic vbusDetect,
    input wire logic vbusAbove3v7,
    input wire logic vbusOverride,
    input wire logic uartCts,
    input wire logic ctsPolarity,
    input wire logic hostCs_n,
    input wire logic [1:0] hostMode,
    input wire logic cardClk,
    input wire logic [1:0] cardInsertDetect,
    input wire logic [1:0] sdioInt,
    input wire logic sdioPolarity,
    input wire logic corePowerGood,
    input wire logic firmwareLoaded,
    input wire logic softResetReq,
    input wire logic softResetWhole,
    input wire logic [NUM_PADS-1:0] padOutIn,
    input wire logic [NUM_PADS-1:0] padOeIn,
    input wire logic [2*NUM_PADS-1:0] padCfg,
    input wire logic [2*NUM_GROUPS-1:0] driveCfg,
    output logic [2:0] powerMode_r,
    output logic reqBusy_r,
    output logic cpuClkEn_r,
    output logic pllEn_r,
    output logic xtalEn_r,
    output logic usbXcvrEn_r,
    output logic bufferValid_r,
    output logic pcReset_r,
    output logic deviceReset_r,
    output logic firmwareLost_r,
    output logic usbSupplyVbus_r,
    output logic [NUM_PADS-1:0] padOut_r,
    output logic [NUM_PADS-1:0] padOe_r,
    output logic [NUM_PADS-1:0] padPullUp_r,
    output logic [NUM_PADS-1:0] padPullDn_r,
    output logic [2*NUM_GROUPS-1:0] driveStrength_r
);
    // one-hot controller states
    typedef enum logic [5:0] {
        ST_NORMAL = 6'h01,
        ST_DRAIN = 6'h02,
        ST_SUSPEND = 6'h04,
        ST_STANDBY = 6'h08,
        ST_WAKE = 6'h10,
        ST_COREOFF = 6'h20
    } lpm_state_e;

    lpm_state_e state_r; // current controller state
    lpm_state_e state_nxt;
    logic fromStandby_r; // wake sequence began in standby
    logic [SETTLE_W-1:0] settle_r; // oscillator/pll settle countdown
    logic settleDone;
    logic suspendWake;
    logic standbyWake;
    logic lowPower; // pads frozen
    logic wakeDone;

    ////////////////////////////////////////////////////////////////////
    // pin synchroniser
    lpm_sync_if #(.W(SYN_W)) pins ();

    assign pins.raw = {corePowerGood, vbusAbove3v7, cardClk, sdioInt, cardInsertDetect,
                       hostCs_n, uartCts, vbusDetect, usbRoleIdentPin, usbDm, usbDp};

    lpm_pin_sync #(.W(SYN_W), .RST_VAL(SYN_RST)) u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .port(pins)
    );

    ////////////////////////////////////////////////////////////////////
    // wake sources
    always_comb begin
        // usb line moves, role pin change, vbus arrival, cts/sdio levels, cs, cmd5, card
        suspendWake = pins.changed[SYN_DP] | pins.changed[SYN_DM]
                    | pins.changed[SYN_ROLE]
                    | (pins.changed[SYN_VBUS] & pins.level[SYN_VBUS])
                    | (pins.level[SYN_CTS] == ctsPolarity)
                    | ~pins.level[SYN_CS]
                    | sleepCmdRx | wakeCmdRx
                    | pins.changed[SYN_INS0] | pins.changed[SYN_INS1]
                    | (pins.level[SYN_SDIO0] == sdioPolarity)
                    | (pins.level[SYN_SDIO1] == sdioPolarity);
        // usb lines are dead in standby; cs counts only in the parallel host modes
        standbyWake = (pins.changed[SYN_VBUS] & pins.level[SYN_VBUS])
                    | pins.changed[SYN_INS0] | pins.changed[SYN_INS1]
                    | (pins.level[SYN_SDIO0] == sdioPolarity)
                    | (pins.level[SYN_SDIO1] == sdioPolarity)
                    | (pins.level[SYN_CTS] == ctsPolarity)
                    | (~pins.level[SYN_CS] & (hostMode != HOST_CARD))
                    | (pins.changed[SYN_CCLK] & (hostMode == HOST_CARD));
    end

    assign settleDone = (settle_r == '0);
    assign wakeDone = (state_r == ST_WAKE) && settleDone;

    ////////////////////////////////////////////////////////////////////
    // next state; hard reset is rst_n itself and restarts from the top
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_NORMAL: begin
                // standby wins over suspend when both arrive together
                if (fwStandbyReq || hostStandbyReq || sleepCmdRx) begin
                    state_nxt = ST_STANDBY;
                end else if (fwSuspendReq || hostSuspendReq) begin
                    state_nxt = ST_DRAIN;
                end
            end
            ST_DRAIN: begin
                // clocks keep running until the bus goes quiet
                if (busIdle) begin
                    state_nxt = ST_SUSPEND;
                end
            end
            ST_SUSPEND: begin
                if (suspendWake) begin
                    state_nxt = ST_WAKE;
                end
            end
            ST_STANDBY: begin
                if (standbyWake) begin
                    state_nxt = ST_WAKE;
                end
            end
            ST_WAKE: begin
                if (settleDone) begin
                    state_nxt = ST_NORMAL;
                end
            end
            ST_COREOFF: begin
                // supply back: restart in normal so mode and busy flag move with the state
                if (pins.level[SYN_PWR]) begin
                    state_nxt = ST_NORMAL;
                end
            end
            default: begin
                state_nxt = ST_NORMAL;
            end
        endcase
        // losing the core supply overrides everything
        if (!pins.level[SYN_PWR]) begin
            state_nxt = ST_COREOFF;
        end
    end

    // state register; requests outside normal are simply ignored
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_r <= ST_NORMAL;
        end else begin
            state_r <= state_nxt;
        end
    end

    // remember where the wake began and count the settle time
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            fromStandby_r <= 1'b0;
            settle_r <= '0;
        end else if (state_r != ST_WAKE && state_nxt == ST_WAKE) begin
            fromStandby_r <= (state_r == ST_STANDBY);
            // suspend and standby wakes load the same settle count, though standby also restarts the oscillator
            settle_r <= SETTLE_W'(SETTLE_CYC - 1);
        end else if (!settleDone) begin
            settle_r <= settle_r - 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // mode code and busy flag
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            powerMode_r <= MODE_NORMAL;
            reqBusy_r <= 1'b0;
        end else begin
            case (state_nxt)
                ST_NORMAL: powerMode_r <= MODE_NORMAL;
                ST_SUSPEND: powerMode_r <= MODE_SUSPEND;
                ST_STANDBY: powerMode_r <= MODE_STANDBY;
                ST_COREOFF: powerMode_r <= MODE_COREOFF;
                default: powerMode_r <= MODE_TRANSIT;
            endcase
            reqBusy_r <= (state_nxt != ST_NORMAL);
        end
    end

    // clock, pll, oscillator and transceiver enables
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cpuClkEn_r <= 1'b1;
            pllEn_r <= 1'b1;
            xtalEn_r <= 1'b1;
            usbXcvrEn_r <= 1'b1;
        end else begin
            case (state_nxt)
                ST_NORMAL, ST_DRAIN: begin
                    cpuClkEn_r <= 1'b1;
                    pllEn_r <= 1'b1;
                    xtalEn_r <= 1'b1;
                    usbXcvrEn_r <= 1'b1;
                end
                ST_SUSPEND: begin
                    // transceiver stays up so the data lines can wake us
                    cpuClkEn_r <= 1'b0;
                    pllEn_r <= 1'b0;
                    xtalEn_r <= 1'b1;
                    usbXcvrEn_r <= 1'b1;
                end
                ST_WAKE: begin
                    // core clock held off until the pll has settled
                    cpuClkEn_r <= 1'b0;
                    pllEn_r <= 1'b1;
                    xtalEn_r <= 1'b1;
                    usbXcvrEn_r <= 1'b1;
                end
                default: begin
                    cpuClkEn_r <= 1'b0;
                    pllEn_r <= 1'b0;
                    xtalEn_r <= 1'b0;
                    usbXcvrEn_r <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // buffer validity: suspend keeps it, standby and supply loss drop it
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            bufferValid_r <= 1'b0;
        end else if (state_nxt == ST_STANDBY || state_nxt == ST_COREOFF) begin
            bufferValid_r <= 1'b0;
        end else if (state_nxt == ST_NORMAL && state_r == ST_NORMAL) begin
            bufferValid_r <= 1'b1;
        end
    end

    // program counter and device reset pulses
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pcReset_r <= 1'b1;
            deviceReset_r <= 1'b1;
        end else begin
            // suspend wake leaves the counter alone; standby wake restarts the core
            pcReset_r <= (wakeDone && fromStandby_r)
                       || (softResetReq && state_r == ST_NORMAL);
            deviceReset_r <= (softResetReq && softResetWhole && state_r == ST_NORMAL)
                           || (state_r == ST_COREOFF && pins.level[SYN_PWR]);
        end
    end

    // firmware image lost after reset, whole-device reset or supply loss
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            firmwareLost_r <= 1'b1;
        end else if (state_r == ST_COREOFF
                     || (softResetReq && softResetWhole && state_r == ST_NORMAL)) begin
            firmwareLost_r <= 1'b1;
        end else if (firmwareLoaded) begin
            firmwareLost_r <= 1'b0;
        end
    end

    // usb supply source select
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            usbSupplyVbus_r <= 1'b0;
        end else begin
            usbSupplyVbus_r <= pins.level[SYN_VB37] & ~vbusOverride;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pads: freeze in low power, otherwise follow the core and its config
    assign lowPower = (state_r == ST_SUSPEND) || (state_r == ST_STANDBY)
                   || (state_nxt == ST_SUSPEND) || (state_nxt == ST_STANDBY);

    genvar gi;
    generate
        for (gi = 0; gi < NUM_PADS; gi++) begin : g_pad
            logic [1:0] cfg;
            assign cfg = padCfg[2*gi +: 2];
            always_ff @(posedge clock) begin
                if (!rst_n) begin
                    // all pads float during hard reset
                    padOut_r[gi] <= 1'b0;
                    padOe_r[gi] <= 1'b0;
                    padPullUp_r[gi] <= 1'b0;
                    padPullDn_r[gi] <= 1'b0;
                end else if (!lowPower) begin
                    padOut_r[gi] <= padOutIn[gi];
                    padOe_r[gi] <= padOeIn[gi] && (cfg != PAD_TRISTATE);
                    padPullUp_r[gi] <= (cfg == PAD_PULLUP);
                    padPullDn_r[gi] <= (cfg == PAD_PULLDN);
                end else if (state_r == ST_STANDBY && cfg != PAD_HOLD) begin
                    // standby keeps the configuration but need not hold the value
                    padPullUp_r[gi] <= (cfg == PAD_PULLUP);
                    padPullDn_r[gi] <= (cfg == PAD_PULLDN);
                end
            end
        end
    endgenerate

    // drive strength is one code per supply group, not per pin
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            driveStrength_r <= {NUM_GROUPS{DRV_FULL}};
        end else if (!lowPower) begin
            driveStrength_r <= driveCfg;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    normal_clocks_a: assert property ((state_r == ST_NORMAL && $past(state_r) == ST_NORMAL)
        |-> (cpuClkEn_r && pllEn_r))
        else $error("clocks off in normal mode");
    suspend_clocks_a: assert property ((state_r == ST_SUSPEND) |-> (!cpuClkEn_r && !pllEn_r))
        else $error("clocks running in suspend");
    pad_hold_a: assert property ((state_r == ST_SUSPEND && $past(state_r) == ST_SUSPEND)
        |-> ($stable(padOut_r) && $stable(padOe_r)))
        else $error("pad moved during suspend");
    buffer_keep_a: assert property ((state_r == ST_DRAIN ##1 state_r == ST_SUSPEND)
        |-> $stable(bufferValid_r))
        else $error("buffers dropped on suspend");
    drain_wait_a: assert property ((state_r == ST_DRAIN && !busIdle && pins.level[SYN_PWR])
        |=> state_r == ST_DRAIN)
        else $error("suspend entered with bus busy");
    suspend_resume_a: assert property ((state_r == ST_WAKE && !fromStandby_r && settleDone)
        |=> !pcReset_r ##1 state_r == ST_NORMAL)
        else $error("counter reset on suspend wake");
    suspend_entry_a: assert property ((state_r == ST_NORMAL && fwSuspendReq && !fwStandbyReq
        && !hostStandbyReq && !sleepCmdRx && pins.level[SYN_PWR]) |=> state_r == ST_DRAIN)
        else $error("suspend request not taken");
    standby_lost_a: assert property ((state_r == ST_STANDBY) |-> !bufferValid_r)
        else $error("buffer valid in standby");
    standby_pc_a: assert property ((state_r == ST_WAKE && fromStandby_r && settleDone)
        |=> pcReset_r && cpuClkEn_r)
        else $error("core not restarted after standby");
    standby_off_a: assert property ((state_r == ST_STANDBY)
        |-> (!xtalEn_r && !pllEn_r && !usbXcvrEn_r))
        else $error("oscillator on in standby");
    busy_gate_a: assert property ((state_r != ST_NORMAL) |-> reqBusy_r
        && powerMode_r != MODE_NORMAL)
        else $error("busy flag low during transition");
endmodule // lpm_power_ctrl
`default_nettype wire

//--- lpm_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// stands in for the host and firmware: a short bus burst and a firmware reload
module lpm_host_model import lpm_pkg::*; #(
    parameter int DRAIN = 6
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic startTxn,
    input wire logic [2:0] powerMode,
    input wire logic firmwareLost,
    output logic busIdle,
    output logic firmwareLoaded
);
    logic [3:0] txnCnt_r; // cycles left on the outstanding burst
    logic [2:0] lostDly_r; // delay so the lost flag is seen before the reload
    ////////////////////////////////////////////////////////////////////////
    // a burst keeps the bus busy, so suspend entry has to wait for it
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            txnCnt_r <= '0;
        end else if (startTxn) begin
            txnCnt_r <= 4'(DRAIN);
        end else if (txnCnt_r != 4'h0) begin
            txnCnt_r <= txnCnt_r - 4'h1;
        end
    end
    assign busIdle = (txnCnt_r == 4'h0);
    // reload only in normal mode; a dead core cannot take firmware
    always_ff @(posedge clock) begin
        lostDly_r <= {lostDly_r[1:0], firmwareLost};
        firmwareLoaded <= lostDly_r[2] && (powerMode == MODE_NORMAL);
    end
endmodule // lpm_host_model
`default_nettype wire

//--- low_power_mode_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module low_power_mode_control_tb_top import lpm_pkg::*;;
    logic clock = 0, rst_n = 0; // clock and synchronous reset
    logic fwSuspendReq = 0, hostSuspendReq = 0, fwStandbyReq = 0, hostStandbyReq = 0;
    logic sleepCmdRx = 0, wakeCmdRx = 0, busIdle, startTxn = 0, firmwareLoaded;
    logic usbDp = 0, usbDm = 0, usbRoleIdentPin = 0, vbusDetect = 0, vbusAbove3v7 = 0;
    logic vbusOverride = 0, uartCts = 0, ctsPolarity = 1, hostCs_n = 1, cardClk = 0;
    logic sdioPolarity = 1, corePowerGood = 1, softResetReq = 0, softResetWhole = 0;
    logic [1:0] hostMode = HOST_SRAM, cardInsertDetect = 0, sdioInt = 0;
    logic [7:0] padOutIn = 0, padOeIn = 0, padOut_r, padOe_r, padPullUp_r, padPullDn_r, pv;
    logic [15:0] padCfg = 0;
    logic [11:0] driveCfg = 0, driveStrength_r;
    logic [2:0] powerMode_r, lastMode = MODE_NORMAL;
    logic reqBusy_r, cpuClkEn_r, pllEn_r, xtalEn_r, usbXcvrEn_r, bufferValid_r;
    logic pcReset_r, deviceReset_r, firmwareLost_r, usbSupplyVbus_r;
    logic [2:0] modeQ[$]; // expected mode changes, oldest first
    int num_errors = 0, checks = 0, seed = 32'h33e5480e;
    int sbSrc[6] = '{3, 4, 5, 6, 7, 10}; // wake sources valid in standby
    always #2 clock = ~clock;
    lpm_power_ctrl #(.SETTLE_CYC(4)) lpm_power_ctrl_inst (.clock, .rst_n, .fwSuspendReq,
        .hostSuspendReq, .fwStandbyReq, .hostStandbyReq, .sleepCmdRx, .wakeCmdRx, .busIdle,
        .usbDp, .usbDm, .usbRoleIdentPin, .vbusDetect, .vbusAbove3v7, .vbusOverride, .uartCts,
        .ctsPolarity, .hostCs_n, .hostMode, .cardClk, .cardInsertDetect, .sdioInt, .sdioPolarity,
        .corePowerGood, .firmwareLoaded, .softResetReq, .softResetWhole, .padOutIn, .padOeIn,
        .padCfg, .driveCfg, .powerMode_r, .reqBusy_r, .cpuClkEn_r, .pllEn_r, .xtalEn_r,
        .usbXcvrEn_r, .bufferValid_r, .pcReset_r, .deviceReset_r, .firmwareLost_r,
        .usbSupplyVbus_r, .padOut_r, .padOe_r, .padPullUp_r, .padPullDn_r, .driveStrength_r);
    lpm_host_model lpm_host_model_inst (.clock, .rst_n, .startTxn, .powerMode(powerMode_r),
        .firmwareLost(firmwareLost_r), .busIdle, .firmwareLoaded);
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        if (num_errors == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask
    // bounded wait; values are read at the edge, before that edge's updates land
    task automatic waitMode(input logic [2:0] m);
        for (int i = 0; i < 200 && powerMode_r !== m; i++) tick(1);
        chk(powerMode_r, m);
    endtask
    // drive one wake source active (on) or back to idle; toggles only act when on
    task automatic setSrc(input int s, input logic on);
        case (s)
            0: if (on) usbDp <= ~usbDp;
            1: if (on) usbDm <= ~usbDm;
            2: if (on) usbRoleIdentPin <= ~usbRoleIdentPin;
            3: vbusDetect <= on;
            4: uartCts <= on ~^ ctsPolarity;
            5: hostCs_n <= ~on;
            6: if (on) cardInsertDetect[1] <= ~cardInsertDetect[1];
            7: sdioInt[0] <= on ~^ sdioPolarity;
            8: wakeCmdRx <= on;
            9: sleepCmdRx <= on;
            default: if (on) cardClk <= ~cardClk;
        endcase
    endtask
    ////////////////////////////////////////////////////////////////////////
    // one trip to a low-power mode and back; k picks the request, s the wake source
    task automatic lowTrip(input int k, input int s);
        logic sb;
        sb = (k >= 2);
        padOutIn <= 8'($random(seed));
        hostMode <= (s == 10) ? HOST_CARD : HOST_SRAM;
        tick(2);
        pv = padOutIn;
        if (sb) modeQ = {modeQ, MODE_STANDBY, MODE_TRANSIT, MODE_NORMAL};
        else modeQ = {modeQ, MODE_TRANSIT, MODE_SUSPEND, MODE_TRANSIT, MODE_NORMAL};
        case (k)
            0: fwSuspendReq <= 1'b1;
            1: hostSuspendReq <= 1'b1;
            2: fwStandbyReq <= 1'b1;
            3: hostStandbyReq <= 1'b1;
            default: sleepCmdRx <= 1'b1;
        endcase
        startTxn <= !sb;
        tick(1);
        {fwSuspendReq, hostSuspendReq, fwStandbyReq, hostStandbyReq, sleepCmdRx, startTxn} <= '0;
        tick(2);
        fwStandbyReq <= 1'b1; // must be ignored while busy
        if (!sb) chk(powerMode_r, MODE_TRANSIT);
        tick(1);
        fwStandbyReq <= 1'b0;
        waitMode(sb ? MODE_STANDBY : MODE_SUSPEND);
        padOutIn <= ~pv; // pads must not follow this while frozen
        tick(2);
        chk(reqBusy_r, 1);
        chk({cpuClkEn_r, pllEn_r}, 0);
        chk({xtalEn_r, usbXcvrEn_r}, sb ? 0 : 3);
        chk(bufferValid_r, !sb);
        chk(padOut_r, pv);
        setSrc(s, 1);
        tick(1);
        if (s >= 8) setSrc(s, 0);
        waitMode(MODE_NORMAL);
        chk(pcReset_r, sb);
        tick(2);
        chk({cpuClkEn_r, pllEn_r, bufferValid_r, reqBusy_r}, 14);
        setSrc(s, 0);
        tick(4);
    endtask
    // every mode change is matched against the oldest note
    always @(posedge clock) begin
        if (rst_n && powerMode_r !== lastMode) begin
            lastMode = powerMode_r;
            if (modeQ.size() == 0) chk(powerMode_r, 3'h7);
            else chk(powerMode_r, modeQ.pop_front());
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        tick(4);
        rst_n <= 1'b1;
        tick(1);
        chk({firmwareLost_r, cpuClkEn_r, pllEn_r}, 7);
        padOeIn <= 8'($random(seed));
        driveCfg <= 12'($random(seed));
        vbusAbove3v7 <= 1'b1;
        for (int i = 0; i < 8; i++) padCfg[2*i +: 2] <= 2'($random(seed));
        tick(8);
        chk(firmwareLost_r, 0);
        chk(driveStrength_r, driveCfg);
        for (int i = 0; i < 8; i++) begin
            chk(padOe_r[i], padOeIn[i] && padCfg[2*i +: 2] != PAD_TRISTATE);
            chk({padPullUp_r[i], padPullDn_r[i]}, {padCfg[2*i +: 2] == PAD_PULLUP,
                padCfg[2*i +: 2] == PAD_PULLDN});
        end
        chk(usbSupplyVbus_r, 1);
        vbusOverride <= 1'b1;
        tick(3);
        chk(usbSupplyVbus_r, 0);
        for (int w = 0; w < 2; w++) begin
            softResetReq <= 1'b1;
            softResetWhole <= w[0];
            tick(1);
            softResetReq <= 1'b0;
            tick(1);
            chk({pcReset_r, deviceReset_r, firmwareLost_r}, {1'b1, w[0], w[0]});
            tick(10);
        end
        for (int s = 0; s < 10; s++) lowTrip(s % 2, s);
        for (int i = 0; i < 6; i++) lowTrip(2 + i % 3, sbSrc[i]);
        modeQ = {modeQ, MODE_COREOFF, MODE_NORMAL};
        corePowerGood <= 1'b0;
        waitMode(MODE_COREOFF);
        tick(1);
        chk({cpuClkEn_r, firmwareLost_r}, 1);
        corePowerGood <= 1'b1;
        waitMode(MODE_NORMAL);
        tick(4);
        chk(16'(modeQ.size()), 0);
        summarize();
    end
    // watchdog far beyond the expected run length
    initial begin
        tick(20000);
        num_errors++;
        summarize();
    end
endmodule // low_power_mode_control_tb_top
`default_nettype wire
